// >>> design/asp_pkg.sv
/*
  constants for the full-duplex asynchronous serial port: register addresses,
  control-register field positions, reset values and state encodings.
  assumes the host cpu decodes special-function addresses as 8-bit values.
*/
package asp_pkg;

    // ============================================================
    // register addresses on the special-function bus
    localparam logic [7:0] ASP_ADDR_CONTROL = 8'h98;
    localparam logic [7:0] ASP_ADDR_DATA    = 8'h99;

    // ============================================================
    // control register field positions
    localparam int ASP_BIT_FORMAT   = 7;
    localparam int ASP_BIT_UNUSED   = 6;
    localparam int ASP_BIT_MPFILTER = 5;
    localparam int ASP_BIT_RXEN     = 4;
    localparam int ASP_BIT_TX9      = 3;
    localparam int ASP_BIT_RX9      = 2;
    localparam int ASP_BIT_TXDONE   = 1;
    localparam int ASP_BIT_RXDONE   = 0;

    // ============================================================
    // reset values and fixed readings
    localparam logic [7:0] ASP_CONTROL_RESET = 8'h40;
    localparam logic [7:0] ASP_DATA_RESET    = 8'h00;
    localparam logic       ASP_UNUSED_READ   = 1'b1;
    localparam logic       ASP_LINE_IDLE     = 1'b1;
    localparam logic       ASP_START_LEVEL   = 1'b0;
    localparam logic [7:0] ASP_TIMER_MAX     = 8'hff;

    // ============================================================
    // frame shape
    localparam logic [2:0] ASP_LAST_DATA_BIT = 3'h7;
    localparam logic [2:0] ASP_BITCNT_RESET  = 3'h0;
    localparam int         ASP_BUF_DEPTH     = 2;
    localparam logic [1:0] ASP_BUF_FULL      = 2'h2;
    localparam logic [1:0] ASP_BUF_EMPTY     = 2'h0;

    // ============================================================
    // frame sequencer states, gray coded from idle to stop along the 9-bit path
    typedef enum logic [2:0] {
        ASP_IDLE  = 3'b000,
        ASP_START = 3'b001,
        ASP_DATA  = 3'b011,
        ASP_NINTH = 3'b010,
        ASP_STOP  = 3'b110
    } asp_state_type;

endpackage : asp_pkg

// >>> design/asp_serial_port.sv
/*
  full-duplex asynchronous serial port with 8-bit and 9-bit frames,
  a control register and a shared transmit/receive data buffer location.
  assumes a cpu special-function bus (address, one-cycle read and write
  strobes), a timer clock tick and a transmit timer overflow pulse from the
  baud timer, both one cycle wide and synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module asp_serial_port
    import asp_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       clk_en,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output var  logic [7:0] sfr_rdata,
    input  wire logic       baud_clk_tick,
    input  wire logic       tx_timer_overflow,
    input  wire logic [7:0] baud_timer_reload,
    input  wire logic       int_enable,
    output var  logic       int_request,
    output var  logic       tx_buffer_ready,
    input  wire logic       serial_in_pin,
    output var  logic       serial_out_pin
);

    // ============================================================
    // address decode
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        addr_hit = (a == target);
    endfunction : addr_hit

    wire logic ctl_wr  = clk_en & sfr_wr & addr_hit(sfr_addr, ASP_ADDR_CONTROL);
    wire logic data_wr = clk_en & sfr_wr & addr_hit(sfr_addr, ASP_ADDR_DATA);

    // ============================================================
    // control register fields
    logic       frame_format_select;
    logic       multiproc_filter_enable;
    logic       receive_enable_bit;
    logic       transmit_ninth_bit;
    logic       received_ninth_bit;
    logic       transmit_done_flag;
    logic       receive_done_flag;
    logic [7:0] rx_latch;

    wire logic [7:0] control_view = {frame_format_select, ASP_UNUSED_READ,
                                     multiproc_filter_enable, receive_enable_bit,
                                     transmit_ninth_bit, received_ninth_bit,
                                     transmit_done_flag, receive_done_flag};

    // reads of the data location only ever see the receive latch
    wire logic [7:0] read_mux = addr_hit(sfr_addr, ASP_ADDR_CONTROL) ? control_view :
                                addr_hit(sfr_addr, ASP_ADDR_DATA)    ? rx_latch     :
                                8'h00;

    // ============================================================
    // two-entry transmit buffer between cpu writes and the shifter
    logic [7:0] txq_mem [ASP_BUF_DEPTH];
    logic       txq_wp;
    logic       txq_rp;
    logic [1:0] txq_cnt;
    logic       tx_pop;

    wire logic       txq_valid = (txq_cnt != ASP_BUF_EMPTY);
    wire logic       txq_push  = data_wr & (txq_cnt != ASP_BUF_FULL);
    wire logic [1:0] next_txq_cnt = (txq_push & ~tx_pop) ? txq_cnt + 2'h1 :
                                    (~txq_push & tx_pop) ? txq_cnt - 2'h1 : txq_cnt;

    // ============================================================
    // transmit bit timing: overflow halved
    logic          tx_half;
    asp_state_type tx_state;
    logic [2:0]    tx_bitcnt;
    logic [7:0]    tx_shift;

    wire logic tx_tick = clk_en & tx_timer_overflow & tx_half;
    assign tx_pop = tx_tick & (tx_state == ASP_IDLE) & txq_valid;

    wire logic tx_last_data = (tx_state == ASP_DATA) & (tx_bitcnt == ASP_LAST_DATA_BIT);
    // done is raised as the stop bit begins, in either frame format
    wire logic tx_done_set  = tx_tick & ((tx_last_data & ~frame_format_select) |
                                         (tx_state == ASP_NINTH));

    // ============================================================
    // receive timer copy and bit sampling
    logic          rx_prev;
    logic [7:0]    rx_timer;
    logic          rx_phase;
    asp_state_type rx_state;
    logic [2:0]    rx_bitcnt;
    logic [7:0]    rx_shift;
    logic          rx_ninth;

    // a falling edge on an idle receiver restarts the timer copy so the
    // frame is timed from its own start, not from the transmit timer
    wire logic rx_start_edge = (rx_state == ASP_IDLE) & receive_enable_bit &
                               rx_prev & ~serial_in_pin;
    wire logic rx_overflow   = baud_clk_tick & (rx_timer == ASP_TIMER_MAX);
    // first overflow after the edge is mid start bit, then every second one
    wire logic rx_sample     = clk_en & rx_overflow & ~rx_phase & (rx_state != ASP_IDLE);

    // ============================================================
    // receive load decision at the stop sample
    wire logic rx_at_stop  = rx_sample & (rx_state == ASP_STOP);
    wire logic rx_new_ninth = frame_format_select ? rx_ninth : serial_in_pin;
    // in 8-bit mode the filter checks the stop level, in 9-bit the ninth bit
    wire logic rx_filter_ok = ~multiproc_filter_enable | rx_new_ninth;
    // a pending flag means overrun: the new frame is dropped whole
    wire logic rx_load = rx_at_stop & ~receive_done_flag & rx_filter_ok;

    // set wins over a software clear in the same cycle
    wire logic next_tx_done = tx_done_set |
                              (ctl_wr ? sfr_wdata[ASP_BIT_TXDONE] : transmit_done_flag);
    wire logic next_rx_done = rx_load |
                              (ctl_wr ? sfr_wdata[ASP_BIT_RXDONE] : receive_done_flag);
    wire logic next_rx9     = rx_load ? rx_new_ninth :
                              (ctl_wr ? sfr_wdata[ASP_BIT_RX9] : received_ninth_bit);

    // ============================================================
    // control register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            frame_format_select     <= ASP_CONTROL_RESET[ASP_BIT_FORMAT];
            multiproc_filter_enable <= ASP_CONTROL_RESET[ASP_BIT_MPFILTER];
            receive_enable_bit      <= ASP_CONTROL_RESET[ASP_BIT_RXEN];
            transmit_ninth_bit      <= ASP_CONTROL_RESET[ASP_BIT_TX9];
        end else if (ctl_wr) begin
            frame_format_select     <= sfr_wdata[ASP_BIT_FORMAT];
            multiproc_filter_enable <= sfr_wdata[ASP_BIT_MPFILTER];
            receive_enable_bit      <= sfr_wdata[ASP_BIT_RXEN];
            transmit_ninth_bit      <= sfr_wdata[ASP_BIT_TX9];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            received_ninth_bit <= ASP_CONTROL_RESET[ASP_BIT_RX9];
            transmit_done_flag <= ASP_CONTROL_RESET[ASP_BIT_TXDONE];
            receive_done_flag  <= ASP_CONTROL_RESET[ASP_BIT_RXDONE];
            rx_latch           <= ASP_DATA_RESET;
        end else if (clk_en) begin
            received_ninth_bit <= next_rx9;
            transmit_done_flag <= next_tx_done;
            receive_done_flag  <= next_rx_done;
            if (rx_load) begin
                rx_latch <= rx_shift;
            end
        end
    end

    // ============================================================
    // bus read data and interrupt request
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata   <= 8'h00;
            int_request <= 1'b0;
        end else if (clk_en) begin
            if (sfr_rd) begin
                sfr_rdata <= read_mux;
            end
            int_request <= int_enable & (next_tx_done | next_rx_done);
        end
    end

    // ============================================================
    // transmit buffer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            txq_wp          <= 1'b0;
            txq_rp          <= 1'b0;
            txq_cnt         <= ASP_BUF_EMPTY;
            tx_buffer_ready <= 1'b1;
        end else if (clk_en) begin
            if (txq_push) begin
                txq_wp <= ~txq_wp;
            end
            if (tx_pop) begin
                txq_rp <= ~txq_rp;
            end
            txq_cnt         <= next_txq_cnt;
            tx_buffer_ready <= (next_txq_cnt != ASP_BUF_FULL);
        end
    end

    // storage only, no reset needed
    always_ff @(posedge clk_sys) begin
        if (txq_push) begin
            txq_mem[txq_wp] <= sfr_wdata;
        end
    end

    // ============================================================
    // transmitter
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_half        <= 1'b0;
            tx_state       <= ASP_IDLE;
            tx_bitcnt      <= ASP_BITCNT_RESET;
            tx_shift       <= ASP_DATA_RESET;
            serial_out_pin <= ASP_LINE_IDLE;
        end else if (clk_en) begin
            if (tx_timer_overflow) begin
                tx_half <= ~tx_half;
            end
            if (tx_tick) begin
                unique case (tx_state)
                    ASP_IDLE: begin
                        if (txq_valid) begin
                            tx_shift       <= txq_mem[txq_rp];
                            serial_out_pin <= ASP_START_LEVEL;
                            tx_state       <= ASP_START;
                        end
                    end
                    ASP_START: begin
                        serial_out_pin <= tx_shift[0];
                        tx_shift       <= {1'b0, tx_shift[7:1]};
                        tx_bitcnt      <= ASP_BITCNT_RESET;
                        tx_state       <= ASP_DATA;
                    end
                    ASP_DATA: begin
                        if (tx_bitcnt == ASP_LAST_DATA_BIT) begin
                            if (frame_format_select) begin
                                serial_out_pin <= transmit_ninth_bit;
                                tx_state       <= ASP_NINTH;
                            end else begin
                                serial_out_pin <= ASP_LINE_IDLE;
                                tx_state       <= ASP_STOP;
                            end
                        end else begin
                            serial_out_pin <= tx_shift[0];
                            tx_shift       <= {1'b0, tx_shift[7:1]};
                            tx_bitcnt      <= tx_bitcnt + 3'h1;
                        end
                    end
                    ASP_NINTH: begin
                        serial_out_pin <= ASP_LINE_IDLE;
                        tx_state       <= ASP_STOP;
                    end
                    ASP_STOP: begin
                        tx_state <= ASP_IDLE;
                    end
                    default: begin
                        serial_out_pin <= ASP_LINE_IDLE;
                        tx_state       <= ASP_IDLE;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // receive timer copy
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_prev  <= ASP_LINE_IDLE;
            rx_timer <= 8'h00;
            rx_phase <= 1'b0;
        end else if (clk_en) begin
            rx_prev <= serial_in_pin;
            if (rx_start_edge) begin
                rx_timer <= baud_timer_reload;
                rx_phase <= 1'b0;
            end else if (baud_clk_tick) begin
                rx_timer <= rx_overflow ? baud_timer_reload : rx_timer + 8'h01;
                if (rx_overflow) begin
                    rx_phase <= ~rx_phase;
                end
            end
        end
    end

    // ============================================================
    // receiver
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_state  <= ASP_IDLE;
            rx_bitcnt <= ASP_BITCNT_RESET;
            rx_shift  <= ASP_DATA_RESET;
            rx_ninth  <= 1'b0;
        end else if (clk_en) begin
            if (rx_start_edge) begin
                rx_state <= ASP_START;
            end else if (~receive_enable_bit) begin
                rx_state <= ASP_IDLE;
            end else if (rx_sample) begin
                unique case (rx_state)
                    ASP_START: begin
                        // a glitch that is high at mid start bit is no frame
                        rx_state  <= (serial_in_pin == ASP_START_LEVEL) ? ASP_DATA : ASP_IDLE;
                        rx_bitcnt <= ASP_BITCNT_RESET;
                    end
                    ASP_DATA: begin
                        rx_shift  <= {serial_in_pin, rx_shift[7:1]};
                        rx_bitcnt <= rx_bitcnt + 3'h1;
                        if (rx_bitcnt == ASP_LAST_DATA_BIT) begin
                            rx_state <= frame_format_select ? ASP_NINTH : ASP_STOP;
                        end
                    end
                    ASP_NINTH: begin
                        rx_ninth <= serial_in_pin;
                        rx_state <= ASP_STOP;
                    end
                    ASP_STOP: begin
                        rx_state <= ASP_IDLE;
                    end
                    default: begin
                        rx_state <= ASP_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : asp_serial_port

`default_nettype wire

// >>> tb/asp_serial_port_checker.sv
/*
  concurrent checks on the serial port top-level ports.
  assumes one clk_sys domain with nrst asynchronous and active low.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_checker
    import asp_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       tx_timer_overflow,
    input wire logic       int_enable,
    input wire logic       int_request,
    input wire logic       tx_buffer_ready,
    input wire logic       serial_out_pin
);
    // ============================================================
    // bus decode
    wire ctl_wr = clk_en && sfr_wr && (sfr_addr == ASP_ADDR_CONTROL);
    wire dat_wr = clk_en && sfr_wr && (sfr_addr == ASP_ADDR_DATA);
    wire ctl_rd = clk_en && sfr_rd && (sfr_addr == ASP_ADDR_CONTROL);
    wire odd_rd = clk_en && sfr_rd && (sfr_addr != ASP_ADDR_CONTROL) && (sfr_addr != ASP_ADDR_DATA);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // ============================================================
    // properties
    property p_int_off; !int_enable |=> !int_request; endproperty
    a_int_off: assert property (p_int_off) else $error("interrupt high while disabled");
    property p_int_rise; $rose(int_request) |-> $past(int_enable); endproperty
    a_int_rise: assert property (p_int_rise) else $error("interrupt rose without enable");
    // flags fall only by a software write, or the request by dropping the enable
    property p_int_fall; $fell(int_request) |-> $past(ctl_wr) || $past(ctl_wr, 2) || $past(!int_enable); endproperty
    a_int_fall: assert property (p_int_fall) else $error("interrupt fell without cause");
    property p_line_tick; $changed(serial_out_pin) |-> $past(tx_timer_overflow); endproperty
    a_line_tick: assert property (p_line_tick) else $error("transmit line moved off a tick");
    property p_start; dat_wr && tx_buffer_ready |-> ##[1:300] !serial_out_pin; endproperty
    a_start: assert property (p_start) else $error("no start bit after data write");
    property p_ready_fall; $fell(tx_buffer_ready) |-> $past(dat_wr) || $past(dat_wr, 2); endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("buffer filled without a write");
    property p_rd_hold; !(clk_en && sfr_rd) |=> $stable(sfr_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
    property p_unmapped; odd_rd |=> sfr_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_bit6; ctl_rd |=> sfr_rdata[ASP_BIT_UNUSED] == ASP_UNUSED_READ; endproperty
    a_bit6: assert property (p_bit6) else $error("control bit 6 not read as one");

    c_int: cover property ($rose(int_request));
    c_full: cover property ($fell(tx_buffer_ready));
    c_frame: cover property ($fell(serial_out_pin));
endmodule : asp_serial_port_checker

bind asp_serial_port asp_serial_port_checker i_chk (.clk_sys, .nrst, .clk_en, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_rdata, .tx_timer_overflow, .int_enable, .int_request, .tx_buffer_ready, .serial_out_pin);
`default_nettype wire

// >>> tb/asp_remote_node.sv
/*
  remote serial node: sends frames to the port and decodes frames from it.
  assumes eight clk_sys cycles per bit on both lines, same frame format both ways.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_remote_node (
    input  wire logic clk_sys,
    input  wire logic nine,
    input  wire logic line_in,
    output var  logic line_out
);
    localparam int BIT_CYC = 8;
    logic [7:0] got  [0:7];
    logic       got9 [0:7];
    logic       gots [0:7];
    int         count = 0;

    initial line_out = 1'b1; // idle high between frames

    // ============================================================
    // sender, lsb first; the testbench picks ninth and stop levels
    task automatic send_frame(input logic [7:0] d, input logic n9, input logic stp);
        logic [10:0] bits;
        int          nb;
        bits = nine ? {stp, n9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        nb = nine ? 11 : 10;
        @(negedge clk_sys);
        for (int i = 0; i < nb; i++) begin
            line_out = bits[i];
            repeat (BIT_CYC) @(negedge clk_sys);
        end
        line_out = 1'b1;
        repeat (2 * BIT_CYC) @(negedge clk_sys);
    endtask : send_frame

    // ============================================================
    // receiver samples mid bit; a short gap is enough since the stop sample ends the frame
    always begin
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_sys);
            got[count % 8][i] = line_in;
        end
        if (nine) begin
            repeat (BIT_CYC) @(posedge clk_sys);
            got9[count % 8] = line_in;
        end
        repeat (BIT_CYC) @(posedge clk_sys);
        gots[count % 8] = line_in;
        count = count + 1;
    end
endmodule : asp_remote_node
`default_nettype wire

// >>> tb/asp_serial_port_test.sv
/*
  self-checking bench for the serial port, with a remote node on its lines.
  assumes the port samples on the rising edge; the bench drives on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_test
    import asp_pkg::*;
;
    logic       clk_sys, nrst, sfr_wr, sfr_rd, int_enable, node_nine;
    logic       ovf = 1'b0;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic       int_request, tx_buffer_ready, to_node, from_node;
    logic [1:0] tdiv = 2'h0;
    int         errors = 0, tests_run = 0, cycles = 0, base;

    // one overflow pulse feeds both timers, so a bit lasts eight cycles
    asp_serial_port i_dut (.clk_sys, .nrst, .clk_en(1'b1), .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .baud_clk_tick(ovf), .tx_timer_overflow(ovf), .baud_timer_reload(8'hff), .int_enable, .int_request,
        .tx_buffer_ready, .serial_in_pin(from_node), .serial_out_pin(to_node));
    asp_remote_node i_node (.clk_sys, .nine(node_nine), .line_in(to_node), .line_out(from_node));

    // ============================================================
    // clock, ticks, watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        tdiv <= tdiv + 2'h1;
        ovf  <= (tdiv == 2'h3);
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            close_out();
        end
    end

    // ============================================================
    // helpers
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte
    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string what);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        chk_byte(what, e, sfr_rdata);
    endtask : rc
    task automatic wait_rx(input int n);
        int k;
        k = 0;
        while (i_node.count < n && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        // a stalled link must end the run, not let stale slots be compared
        if (k >= 3000) begin
            errors++;
            $display("[ERR] remote frame count expected %0d seen %0d", n, i_node.count);
            close_out();
        end
    endtask : wait_rx
    task automatic rx_case(input logic [7:0] d, input logic n9, input logic stp,
                           input logic [7:0] ctl_exp, input logic [7:0] dat_exp);
        i_node.send_frame(d, n9, stp);
        rc(ASP_ADDR_CONTROL, ctl_exp, "rx control");
        rc(ASP_ADDR_DATA, dat_exp, "rx data");
    endtask : rx_case

    // ============================================================
    // scenarios
    task automatic t_regs();
        rc(ASP_ADDR_CONTROL, ASP_CONTROL_RESET, "control reset");
        rc(ASP_ADDR_DATA, ASP_DATA_RESET, "data reset");
        wr(ASP_ADDR_CONTROL, 8'h28);
        rc(ASP_ADDR_CONTROL, 8'h68, "control bits");
        rc(8'h97, 8'h00, "unmapped");
        $display("test regs done");
    endtask : t_regs
    task automatic t_tx8();
        logic [7:0] exp [0:3];
        logic [7:0] d;
        logic       full;
        int         n;
        n = 0;
        full = 1'b0;
        node_nine = 1'b0;
        int_enable = 1'b1;
        wr(ASP_ADDR_CONTROL, 8'h08);
        base = i_node.count;
        for (int i = 0; i < 4; i++) begin
            d = 8'ha0 + 8'(i);
            // ready seen as the strobe rises is what the push edge uses; a pop in between would mislead
            @(negedge clk_sys);
            if (tx_buffer_ready === 1'b1) begin
                exp[n] = d;
                n++;
            end else begin
                full = 1'b1;
            end
            sfr_addr  = ASP_ADDR_DATA;
            sfr_wdata = d;
            sfr_wr    = 1'b1;
            @(negedge clk_sys);
            sfr_wr = 1'b0;
        end
        wait_rx(base + n);
        for (int i = 0; i < n; i++) begin
            chk_byte("tx byte", exp[i], i_node.got[(base + i) % 8]);
            chk_bit("tx stop", 1'b1, i_node.gots[(base + i) % 8]);
        end
        chk_bit("int tx", 1'b1, int_request);
        repeat (100) @(negedge clk_sys);
        chk_bit("buffer refused", 1'b1, full);
        chk_byte("tx count", 8'(base + n), 8'(i_node.count));
        chk_bit("buffer drained", 1'b1, tx_buffer_ready);
        rc(ASP_ADDR_CONTROL, 8'h4a, "tx done");
        wr(ASP_ADDR_CONTROL, 8'h00);
        rc(ASP_ADDR_CONTROL, 8'h40, "tx clear");
        $display("test tx8 done");
    endtask : t_tx8
    task automatic t_tx9();
        node_nine = 1'b1;
        for (int i = 0; i < 2; i++) begin
            base = i_node.count;
            wr(ASP_ADDR_CONTROL, (i == 0) ? 8'h88 : 8'h80);
            wr(ASP_ADDR_DATA, 8'h3c);
            wait_rx(base + 1);
            chk_byte("tx9 byte", 8'h3c, i_node.got[base % 8]);
            chk_bit("tx ninth", (i == 0), i_node.got9[base % 8]);
        end
        $display("test tx9 done");
    endtask : t_tx9
    task automatic t_rx();
        node_nine = 1'b0;
        wr(ASP_ADDR_CONTROL, 8'h10);
        rx_case(8'h5a, 1'b0, 1'b1, 8'h55, 8'h5a);
        chk_bit("int rx", 1'b1, int_request);
        rx_case(8'h11, 1'b0, 1'b1, 8'h55, 8'h5a);
        wr(ASP_ADDR_CONTROL, 8'h30);
        rx_case(8'h22, 1'b0, 1'b0, 8'h70, 8'h5a);
        wr(ASP_ADDR_CONTROL, 8'h10);
        rx_case(8'h33, 1'b0, 1'b0, 8'h51, 8'h33);
        node_nine = 1'b1;
        wr(ASP_ADDR_CONTROL, 8'hb0);
        rx_case(8'h44, 1'b0, 1'b1, 8'hf0, 8'h33);
        rx_case(8'h55, 1'b1, 1'b0, 8'hf5, 8'h55);
        wr(ASP_ADDR_CONTROL, 8'h90);
        rx_case(8'h66, 1'b0, 1'b1, 8'hd1, 8'h66);
        int_enable = 1'b0;
        wr(ASP_ADDR_CONTROL, 8'h00);
        rx_case(8'h77, 1'b0, 1'b1, 8'h40, 8'h66);
        $display("test rx done");
    endtask : t_rx

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    initial begin
        nrst = 1'b0;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        int_enable = 1'b0;
        node_nine = 1'b0;
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        t_regs();
        t_tx8();
        t_tx9();
        t_rx();
        close_out();
    end
endmodule : asp_serial_port_test
`default_nettype wire
